//--- verif/tb_trt_timing.sv
/*
 testbench for the transmit start-up timing block.
 assumes the checker is bound in and a 250 MHz clock.
*/
`timescale 1ns/1ps
module tb_trt_timing;
    import trt_pkg::*;
    logic clock = 0, arst_n = 0, read = 0, write = 0, txStart = 0;
    logic txStop = 0, tuneReq = 0, retune = 0, calDone = 0, bitTick = 0;
    logic chipReady = 0, bufAlmostFull = 0, bufWrite = 0, bufEmpty = 0;
    logic gpioTestMux = 0, waitrequest, regEnable, ampEnable, modEnable;
    logic txActive, pllSettled, pllEnable, preambleWindow;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [3:0] byteenable = 4'hf;
    logic [1:0] response;
    logic [2:0] gpioOut;
    int fails = 0, samples_checked = 0;
    always #2 clock = ~clock;
    trt_timing dut (.clock(clock), .arst_n(arst_n), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .response(response), .txStart(txStart),
        .txStop(txStop), .tuneReq(tuneReq), .retune(retune),
        .calDone(calDone), .bitTick(bitTick), .chipReady(chipReady),
        .bufAlmostFull(bufAlmostFull), .bufWrite(bufWrite),
        .bufEmpty(bufEmpty), .gpioTestMux(gpioTestMux),
        .regEnable(regEnable), .ampEnable(ampEnable),
        .modEnable(modEnable), .txActive(txActive),
        .pllSettled(pllSettled), .pllEnable(pllEnable),
        .preambleWindow(preambleWindow), .gpioOut(gpioOut));
    // -----------------------------
    // tasks
    // -----------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask
    // holds the request until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return regEnable;
            1: return ampEnable;
            2: return modEnable;
            default: return pllSettled;
        endcase
    endfunction
    task automatic span(input int s, input logic lvl, output int t);
        t = 0;
        while (sig(s) !== lvl && t < 30000) begin
            @(posedge clock);
            t++;
        end
    endtask
    // one microsecond either way: the tick runs free
    function automatic logic [31:0] near(input int t, input int us);
        return 32'(t >= (us - 1) * US_CYCLES && t <= (us + 1) * US_CYCLES + 8);
    endfunction
    task automatic pulse(input int s);
        case (s)
            0: txStart <= 1'b1;
            1: txStop <= 1'b1;
            2: calDone <= 1'b1;
            3: retune <= 1'b1;
            default: bitTick <= 1'b1;
        endcase
        @(posedge clock);
        {txStart, txStop, calDone, retune, bitTick} <= 5'h0;
        @(posedge clock);
    endtask
    // -----------------------------
    // tests
    // -----------------------------
    initial begin
        #(90000 * 4);
        fails++;
        end_of_test();
    end
    initial begin
        logic [7:0] offs[5] = '{OFF_TX_RAMP, OFF_PLL_TUNE, OFF_BOOST,
                                OFF_TEST_BUS, 8'h00};
        logic [7:0] rst[5] = '{8'h00, {5'd10, 3'd2}, 8'h54, 8'h00, 8'h00};
        logic [7:0] cfg[2] = '{8'h39, 8'h0c};
        logic [7:0] c;
        int t, t2, regUs, ampUs, modUs, startUs;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, offs[i], 32'h0, q);
            check("resetValue", q, {24'h0, rst[i]});
        end
        $display("test registers done");
        for (int k = 0; k < 2; k++) begin
            c = cfg[k];
            regUs = 5 * (c[3:2] + 1);
            ampUs = 5 * (c[1:0] + 1);
            modUs = 4 * c[6:4];
            startUs = (modUs > ampUs) ? modUs : ampUs;
            bus(1'b1, OFF_TX_RAMP, {24'h0, c}, q);
            bus(1'b0, OFF_TX_RAMP, 32'h0, q);
            check("txRampReg", q, {24'h0, c});
            pulse(0);
            span(0, 1'b1, t);
            span(1, 1'b1, t);
            check("regRamp", near(t, regUs), 32'h1);
            span(2, 1'b1, t);
            check("modDelay", near(t, startUs), 32'h1);
            check("txActive", {31'h0, txActive}, 32'h1);
            pulse(1);
            span(2, 1'b0, t);
            span(1, 1'b0, t);
            check("downDelay", near(t, modUs), 32'h1);
            span(0, 1'b0, t);
            check("ampDown", near(t, ampUs), 32'h1);
            $display("test transmit %0d done", k);
        end
        // last start loaded the reset threshold window: drain it first
        repeat (20) pulse(4);
        bus(1'b1, OFF_PLL_TUNE, 32'h11, q);
        bus(1'b1, OFF_BOOST, 32'h08, q);
        check("windowIdle", {31'h0, preambleWindow}, 32'h0);
        tuneReq <= 1'b1;
        repeat (3) @(posedge clock);
        repeat (7) pulse(4);
        check("windowOpen", {31'h0, preambleWindow}, 32'h1);
        pulse(4);
        @(posedge clock);
        check("windowShut", {31'h0, preambleWindow}, 32'h0);
        pulse(2);
        span(3, 1'b1, t);
        check("coldSettle", near(t, 30), 32'h1);
        pulse(3);
        span(3, 1'b0, t);
        span(3, 1'b1, t2);
        check("retuneSettle", near(t + t2 + 2, 20), 32'h1);
        tuneReq <= 1'b0;
        $display("test synthesizer done");
        {chipReady, bufAlmostFull, bufEmpty, gpioTestMux} <= 4'hf;
        bus(1'b1, OFF_TEST_BUS, 32'h1e, q);
        repeat (4) @(posedge clock);
        check("busStates", {29'h0, gpioOut}, 32'h1);
        bus(1'b1, OFF_TEST_BUS, 32'h2b, q);
        repeat (4) @(posedge clock);
        check("busBuffer", {29'h0, gpioOut}, 32'h5);
        gpioTestMux <= 1'b0;
        repeat (6) @(posedge clock);
        check("busOff", {29'h0, gpioOut}, 32'h0);
        $display("test test bus done");
        end_of_test();
    end
endmodule

//--- verif/trt_timing_assertions.sv
/*
 checker for the transmit start-up timing block.
 assumes it is bound to trt_timing and sees only its ports.
*/
`timescale 1ns/1ps
module trt_timing_assertions
    import trt_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire logic regEnable,
    input wire logic ampEnable,
    input wire logic modEnable,
    input wire logic txActive,
    input wire logic pllSettled,
    input wire logic pllEnable,
    input wire logic gpioTestMux,
    input wire logic [2:0] gpioOut
);
    // -----------------------------
    // helper: regulator ramp length
    // -----------------------------
    // tick phase is free, so allow one microsecond short
    localparam int MIN_REG = 4 * US_CYCLES;
    int regCnt;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            regCnt <= 0;
        end else if (!regEnable) begin
            regCnt <= 0;
        end else if (!ampEnable) begin
            regCnt <= regCnt + 1;
        end
    end
    // -----------------------------
    // properties
    // -----------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence sAck;
        !waitrequest ##1 waitrequest;
    endsequence
    sequence sMuxOff;
        !gpioTestMux [*4];
    endsequence
    AST_ACK_ONE: assert property ((read || write) && waitrequest |=> sAck)
        else $error("bus answer not one cycle");
    AST_AMP_NEEDS_REG: assert property (ampEnable |-> regEnable)
        else $error("amplifier on without regulator");
    AST_REG_RAMP: assert property ($rose(ampEnable) |-> regCnt >= MIN_REG)
        else $error("regulator ramp cut short");
    AST_MOD_NEEDS_AMP: assert property (modEnable |-> ampEnable && txActive)
        else $error("modulation without amplifier");
    AST_MOD_AFTER_AMP: assert property ($rose(modEnable) |-> $past(ampEnable))
        else $error("modulation started with amplifier");
    AST_DOWN_ORDER: assert property ($fell(ampEnable) |-> !modEnable)
        else $error("amplifier off before modulation");
    AST_SETTLE_ON: assert property (pllSettled |-> pllEnable)
        else $error("settled while synthesizer off");
    AST_TX_ACTIVE: assert property ($rose(txActive) |-> modEnable)
        else $error("transmit state before modulation");
    AST_TBUS_OFF: assert property (sMuxOff |-> gpioOut == 3'h0)
        else $error("test bus active outside test mode");
endmodule

bind trt_timing trt_timing_assertions chk (.clock(clock), .arst_n(arst_n),
    .read(read), .write(write), .waitrequest(waitrequest),
    .regEnable(regEnable), .ampEnable(ampEnable), .modEnable(modEnable),
    .txActive(txActive), .pllSettled(pllSettled), .pllEnable(pllEnable),
    .gpioTestMux(gpioTestMux), .gpioOut(gpioOut));

//--- verilog/trt_pkg.sv
/*
 transmit ramp, modulation delay, synthesizer settle and preamble window
 timing constants and register map.
 assumes a 250 MHz system clock and a 32-bit avalon-mm register slave.
*/
// Operation
// - wait programmed delay before modulation starts
// - delay field times four microseconds
// - regulator ramp codes give 5..20 us
// - amplifier ramp codes give 5..20 us
// - cold settle is soft plus post-cal
// - soft settle field times ten us
// - soft settle resets to 100 us
// - post-cal settle only after calibration done
// - post-cal field 0..70 us, 10 us
// - post-cal settle resets to 20 us
// - preamble window threshold times four bits
// - test select 30 shows state indicators
// - test select 43 shows buffer signals
// - test select needs gpio test-mux mode
package trt_pkg;
    localparam int CLK_MHZ = 250;
    localparam int US_CYCLES = CLK_MHZ;
    localparam logic [7:0] OFF_TX_RAMP = 8'h52;
    localparam logic [7:0] OFF_PLL_TUNE = 8'h53;
    localparam logic [7:0] OFF_BOOST = 8'h54;
    localparam logic [7:0] OFF_TEST_BUS = 8'h51;
    localparam logic [7:0] OFF_STATUS = 8'hc0;
    localparam logic [7:0] RST_TX_RAMP = 8'h00;
    localparam logic [7:0] RST_PLL_TUNE = 8'h52;
    localparam logic [7:0] RST_BOOST = 8'h54;
    localparam logic [7:0] RST_TEST_BUS = 8'h00;
    localparam int MOD_DLY_LSB = 4;
    localparam int REG_RAMP_LSB = 2;
    localparam int AMP_RAMP_LSB = 0;
    localparam int SOFT_LSB = 3;
    localparam int POSTCAL_LSB = 0;
    localparam int PRE_TH_LSB = 2;
    localparam int TEST_SEL_LSB = 0;
    localparam int MOD_STEP_US = 4;
    localparam int RAMP_BASE_US = 5;
    localparam int SETTLE_STEP_US = 10;
    localparam int PRE_BITS_PER = 4;
    localparam logic [5:0] TB_STATES = 6'h1e;
    localparam logic [5:0] TB_BUFFER = 6'h2b;
    localparam logic [7:0] DEAD_READ = 8'h00;
endpackage

//--- verilog/trt_tick.sv
/*
 microsecond tick generator.
 assumes the system clock rate in the package.
*/
`timescale 1ns/1ps
module trt_tick
    import trt_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    output logic usTick
);
    typedef struct packed {
        logic [8:0] cnt;
        logic tick;
    } trt_tick_t;
    trt_tick_t st, next_st;
    // -------------------------------------------------------------
    // fixed-rate tick
    // -------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt == 9'(US_CYCLES - 1)) begin
            next_st.cnt = 9'h000;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 9'h001;
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign usTick = st.tick;
endmodule

//--- verilog/trt_timing.sv
/*
 transmit start-up timing: regulator ramp, amplifier ramp, modulation
 delay on both ramp directions, synthesizer settle, preamble window and
 a small digital test bus.
 assumes requests from the radio state machine on the same clock and
 avalon-mm with waitrequest from software.
*/
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module trt_timing
    import trt_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    input wire logic txStart,
    input wire logic txStop,
    input wire logic tuneReq,
    input wire logic retune,
    input wire logic calDone,
    input wire logic bitTick,
    input wire logic chipReady,
    input wire logic bufAlmostFull,
    input wire logic bufWrite,
    input wire logic bufEmpty,
    input wire logic gpioTestMux,
    output logic regEnable,
    output logic ampEnable,
    output logic modEnable,
    output logic txActive,
    output logic pllSettled,
    output logic pllEnable,
    output logic preambleWindow,
    output logic [2:0] gpioOut
);
    typedef enum {
        TX_IDLE, TX_REG_RAMP, TX_AMP_RAMP, TX_MOD_DLY, TX_RUN,
        TX_DN_DLY, TX_DN_RAMP
    } trt_tx_t;
    typedef enum {PL_IDLE, PL_WAIT_CAL, PL_SOFT, PL_POST, PL_LOCK}
        trt_pll_t;
    typedef struct packed {
        logic [7:0] txRamp;
        logic [7:0] pllTune;
        logic [7:0] boost;
        logic [7:0] testBus;
        logic [31:0] rdata;
        logic ack;
        logic waitReq;
        trt_tx_t txState;
        logic [8:0] txCnt;
        trt_pll_t plState;
        logic [8:0] plCnt;
        logic [6:0] preCnt;
        logic preWin;
        logic regEn;
        logic ampEn;
        logic modEn;
        logic txAct;
        logic pllOk;
        logic pllEn;
        logic [2:0] gpio;
        logic [1:0] syncMux;
    } trt_st_t;
    trt_st_t st, next_st;
    logic usTick;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [8:0] rampUs(input logic [1:0] code);
        rampUs = 9'(RAMP_BASE_US) * (9'(code) + 9'h001);
    endfunction
    function automatic logic [8:0] modUs(input logic [2:0] code);
        modUs = 9'(MOD_STEP_US) * 9'(code);
    endfunction
    function automatic logic [8:0] settleUs(input logic [4:0] code);
        settleUs = 9'(SETTLE_STEP_US) * 9'(code);
    endfunction
    function automatic logic [7:0] merge(input logic [7:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        merge = be[0] ? wd[7:0] : old;
    endfunction

    trt_tick u_tick (
        .clock(clock),
        .arst_n(arst_n),
        .usTick(usTick)
    );

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ack = 1'b0;
        // single wait cycle then ack; write lands on the ack edge
        if ((read || write) && !st.ack) begin
            next_st.ack = 1'b1;
            next_st.rdata = '0;
            if (address == OFF_TX_RAMP) begin
                next_st.rdata = {24'h0, st.txRamp};
            end else if (address == OFF_PLL_TUNE) begin
                next_st.rdata = {24'h0, st.pllTune};
            end else if (address == OFF_BOOST) begin
                next_st.rdata = {24'h0, st.boost};
            end else if (address == OFF_TEST_BUS) begin
                next_st.rdata = {24'h0, st.testBus};
            end else if (address == OFF_STATUS) begin
                next_st.rdata = {23'h0, st.preWin, st.pllOk, st.txAct,
                    st.modEn, st.ampEn, st.regEn, 3'(st.txState)};
            end else begin
                next_st.rdata = {24'h0, DEAD_READ};
            end
        end
        if (write && st.ack) begin
            if (address == OFF_TX_RAMP) begin
                next_st.txRamp = merge(st.txRamp, writedata, byteenable);
            end else if (address == OFF_PLL_TUNE) begin
                next_st.pllTune = merge(st.pllTune, writedata, byteenable);
            end else if (address == OFF_BOOST) begin
                next_st.boost = merge(st.boost, writedata, byteenable);
            end else if (address == OFF_TEST_BUS) begin
                next_st.testBus = merge(st.testBus, writedata, byteenable);
            end
        end
        next_st.waitReq = !next_st.ack;

        // transmit sequence, counted in microseconds
        if (usTick && st.txCnt != 9'h000) begin
            next_st.txCnt = st.txCnt - 9'h001;
        end
        case (st.txState)
            TX_IDLE: begin
                if (txStart) begin
                    next_st.txState = TX_REG_RAMP;
                    next_st.regEn = 1'b1;
                    next_st.txCnt = rampUs(st.txRamp[REG_RAMP_LSB +: 2]);
                end
            end
            TX_REG_RAMP: begin
                if (st.txCnt == 9'h000) begin
                    next_st.txState = TX_AMP_RAMP;
                    next_st.ampEn = 1'b1;
                    next_st.txCnt = rampUs(st.txRamp[AMP_RAMP_LSB +: 2]);
                end
            end
            TX_AMP_RAMP: begin
                if (st.txCnt == 9'h000) begin
                    next_st.txState = TX_MOD_DLY;
                    // delay runs from amplifier enable, so only the rest
                    // of it is left once the ramp is over
                    if (modUs(st.txRamp[MOD_DLY_LSB +: 3]) >
                        rampUs(st.txRamp[AMP_RAMP_LSB +: 2])) begin
                        next_st.txCnt = modUs(st.txRamp[MOD_DLY_LSB +: 3]) -
                            rampUs(st.txRamp[AMP_RAMP_LSB +: 2]);
                    end
                end
            end
            TX_MOD_DLY: begin
                if (st.txCnt == 9'h000) begin
                    next_st.txState = TX_RUN;
                    next_st.modEn = 1'b1;
                    next_st.txAct = 1'b1;
                end
            end
            TX_RUN: begin
                if (txStop) begin
                    next_st.txState = TX_DN_DLY;
                    next_st.modEn = 1'b0;
                    next_st.txCnt = modUs(st.txRamp[MOD_DLY_LSB +: 3]);
                end
            end
            TX_DN_DLY: begin
                if (st.txCnt == 9'h000) begin
                    next_st.txState = TX_DN_RAMP;
                    next_st.ampEn = 1'b0;
                    next_st.txCnt = rampUs(st.txRamp[AMP_RAMP_LSB +: 2]);
                end
            end
            TX_DN_RAMP: begin
                if (st.txCnt == 9'h000) begin
                    next_st.txState = TX_IDLE;
                    next_st.regEn = 1'b0;
                    next_st.txAct = 1'b0;
                end
            end
            default: begin
                next_st.txState = TX_IDLE;
            end
        endcase

        // synthesizer settle
        if (usTick && st.plCnt != 9'h000) begin
            next_st.plCnt = st.plCnt - 9'h001;
        end
        case (st.plState)
            PL_IDLE: begin
                if (tuneReq) begin
                    next_st.plState = PL_WAIT_CAL;
                    next_st.pllEn = 1'b1;
                    next_st.pllOk = 1'b0;
                end
            end
            PL_WAIT_CAL: begin
                if (calDone) begin
                    next_st.plState = PL_SOFT;
                    next_st.plCnt =
                        settleUs(st.pllTune[SOFT_LSB +: 5]);
                end
            end
            PL_SOFT: begin
                if (st.plCnt == 9'h000) begin
                    next_st.plState = PL_POST;
                    next_st.plCnt =
                        settleUs(5'(st.pllTune[POSTCAL_LSB +: 3]));
                end
            end
            PL_POST: begin
                if (st.plCnt == 9'h000) begin
                    next_st.plState = PL_LOCK;
                    next_st.pllOk = 1'b1;
                end
            end
            PL_LOCK: begin
                if (!tuneReq) begin
                    next_st.plState = PL_IDLE;
                    next_st.pllEn = 1'b0;
                    next_st.pllOk = 1'b0;
                end else if (retune) begin
                    // retune from lock skips the post-cal wait
                    next_st.plState = PL_POST;
                    next_st.pllOk = 1'b0;
                    next_st.plCnt =
                        settleUs(st.pllTune[SOFT_LSB +: 5]);
                end
            end
            default: begin
                next_st.plState = PL_IDLE;
            end
        endcase

        // preamble evaluation window in bit periods
        next_st.preWin = st.preCnt != 7'h00;
        if (txStart || (st.preCnt == 7'h00 && tuneReq && !st.preWin &&
            st.plState == PL_IDLE)) begin
            next_st.preCnt = 7'(PRE_BITS_PER) *
                7'(st.boost[PRE_TH_LSB +: 4]);
        end else if (bitTick && st.preCnt != 7'h00) begin
            next_st.preCnt = st.preCnt - 7'h01;
        end

        // digital test bus
        // mux mode strap comes from pin configuration logic, async here
        next_st.syncMux = {st.syncMux[0], gpioTestMux};
        next_st.gpio = 3'b000;
        if (st.syncMux[1]) begin
            if (st.testBus[TEST_SEL_LSB +: 6] == TB_STATES) begin
                next_st.gpio = {st.txAct, st.pllEn, chipReady};
            end else if (st.testBus[TEST_SEL_LSB +: 6] == TB_BUFFER) begin
                next_st.gpio = {bufEmpty, bufWrite, bufAlmostFull};
            end
        end
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.txRamp <= RST_TX_RAMP;
            st.pllTune <= RST_PLL_TUNE;
            st.boost <= RST_BOOST;
            st.testBus <= RST_TEST_BUS;
            st.txState <= TX_IDLE;
            st.plState <= PL_IDLE;
            st.waitReq <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign readdata = st.rdata;
    assign waitrequest = st.waitReq;
    assign response = 2'b00;
    assign regEnable = st.regEn;
    assign ampEnable = st.ampEn;
    assign modEnable = st.modEn;
    assign txActive = st.txAct;
    assign pllSettled = st.pllOk;
    assign pllEnable = st.pllEn;
    assign preambleWindow = st.preWin;
    assign gpioOut = st.gpio;
endmodule
